// ==== dispense_pkg.sv ====
package dispense_pkg;

    // Operating modes for the dispense sequencer.
    typedef enum logic [1:0] {
        MODE_CONTINUOUS = 2'h0,
        MODE_TIMED = 2'h1,
        MODE_EXTERNAL = 2'h2
    } run_mode_t;

    // Functions selectable for the two configurable inputs.
    typedef enum logic [1:0] {
        CFG_DEFAULT = 2'h0,
        CFG_VALVE_POWER = 2'h1,
        CFG_VALVE_PURGE = 2'h2
    } input_func_t;

    // Programmed timing, all in milliseconds except the count.
    typedef struct packed {
        logic [15:0] pulse_ms;
        logic [15:0] cycle_ms;
        logic [15:0] count;
        logic [6:0] done_ms;
    } dispense_cfg_t;

    // Temperatures in tenths of a degree C.
    typedef struct packed {
        logic [11:0] actual;
        logic [11:0] target;
        logic [11:0] window;
    } temp_info_t;

    localparam int CLK_HZ = 40_000_000;
    localparam int MS_PER_S = 1000;
    localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;
    localparam logic [6:0] DONE_MS_DEFAULT = 7'h06;
    localparam logic [6:0] DONE_MS_MIN = 7'h01;
    localparam logic [6:0] DONE_MS_MAX = 7'h64;
    localparam logic [11:0] TEMP_WINDOW_DEFAULT = 12'h03c;
    localparam int SYNC_STAGES = 2;

endpackage

// ==== ms_timer.sv ====
`timescale 1ns/1ps

// Counts a number of milliseconds after a start pulse and flags the end.
module ms_timer
    import dispense_pkg::*;
#(
    parameter int TICKS_PER_MS = CYCLES_PER_MS
)
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic start,
    input wire logic [15:0] ms,
    output logic busy,
    output logic done
);

    logic [15:0] tick_q;
    logic [15:0] ms_q;

    ////////////////////////////////////////////////////////////////////////
    // A zero length still takes one millisecond so the sequence advances.
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            tick_q <= 16'h0000;
            ms_q <= 16'h0000;
            busy <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (start)
            begin
                tick_q <= 16'h0000;
                ms_q <= (ms == 16'h0000) ? 16'h0001 : ms;
                busy <= 1'b1;
            end
            else if (busy)
            begin
                if (tick_q == 16'(TICKS_PER_MS - 1))
                begin
                    tick_q <= 16'h0000;
                    ms_q <= ms_q - 16'h0001;
                    if (ms_q == 16'h0001)
                    begin
                        busy <= 1'b0;
                        done <= 1'b1;
                    end
                end
                else
                begin
                    tick_q <= tick_q + 16'h0001;
                end
            end
        end
    end

endmodule

// ==== dispense_trigger_io.sv ====
`timescale 1ns/1ps

module dispense_trigger_io
    import dispense_pkg::*;
#(
    parameter int TICKS_PER_MS = CYCLES_PER_MS
)
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic INITIATE_VOLTAGE_IN,
    input wire run_mode_t MODE,
    input wire dispense_cfg_t CFG,
    input wire logic [15:0] EXT_OPEN_MS,
    input wire temp_info_t TEMP,
    input wire logic CFG_IN1,
    input wire logic CFG_IN2,
    input wire input_func_t IN1_FUNC,
    input wire input_func_t IN2_FUNC,
    input wire logic ALARM_EVENT,
    input wire logic ACTUATOR_OVER_TEMP,
    input wire logic CONTROLLER_ON,
    output logic VALVE_OPEN,
    output logic DISPENSE_DONE,
    output logic TEMP_REACHED,
    output logic ERROR_N,
    output logic OVER_TEMP_OK_N,
    output logic POWER_STATUS,
    output logic HEATER_ENABLE,
    output logic VALVE_POWER,
    output logic VALVE_PURGE,
    output logic ERROR_RESET
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_OPEN = 2'b01,
        ST_GAP = 2'b11
    } seq_state_t;

    seq_state_t state_q;
    logic [SYNC_STAGES-1:0] sync_q;
    logic init_prev_q;
    logic init_rise;
    logic init_level;
    logic [15:0] left_q;
    logic [15:0] cycle_hold_q;
    logic alarm_q;
    logic clear_req;
    logic t_start;
    logic [15:0] t_ms;
    logic t_busy;
    logic t_done;
    logic d_start;
    logic d_busy;
    logic d_done;
    logic [6:0] done_ms;

    ////////////////////////////////////////////////////////////////////////
    // Two-stage synchroniser; only the last stage feeds the edge detector.
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            sync_q <= '0;
            init_prev_q <= 1'b0;
        end
        else
        begin
            sync_q <= {sync_q[SYNC_STAGES-2:0], INITIATE_VOLTAGE_IN};
            init_prev_q <= sync_q[SYNC_STAGES-1];
        end
    end

    // Bounce is not filtered; a bouncing input would start extra cycles.
    assign init_level = sync_q[SYNC_STAGES-1];
    assign init_rise = init_level & ~init_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // Timer loads: open time, then, outside MODE_EXTERNAL, gap for the rest of the cycle.
    always_comb
    begin
        t_start = 1'b0;
        t_ms = CFG.pulse_ms;
        unique case (state_q)
            ST_IDLE:
            begin
                if (MODE == MODE_CONTINUOUS)
                    t_start = init_level;
                else
                    t_start = init_rise;
                if (MODE == MODE_EXTERNAL)
                    t_ms = EXT_OPEN_MS;
            end
            ST_OPEN:
            begin
                t_start = t_done && (MODE != MODE_EXTERNAL);
                t_ms = (cycle_hold_q > CFG.pulse_ms) ?
                    cycle_hold_q - CFG.pulse_ms : 16'h0001;
            end
            ST_GAP:
            begin
                t_start = t_done && ((MODE == MODE_CONTINUOUS) ?
                    init_level : (left_q > 16'h0001));
            end
        endcase
    end

    ms_timer #(.TICKS_PER_MS(TICKS_PER_MS)) u_timer (
        .CLK(CLK),
        .ARST_N(ARST_N),
        .start(t_start),
        .ms(t_ms),
        .busy(t_busy),
        .done(t_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Dispense sequencer.  The count is sampled at start of a burst.
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            state_q <= ST_IDLE;
            left_q <= 16'h0000;
            cycle_hold_q <= 16'h0000;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    if (t_start)
                    begin
                        state_q <= ST_OPEN;
                        cycle_hold_q <= CFG.cycle_ms;
                        left_q <= (CFG.count == 16'h0000) ?
                            16'h0001 : CFG.count;
                    end
                end
                ST_OPEN:
                begin
                    if (t_done)
                        state_q <= (MODE == MODE_EXTERNAL) ? ST_IDLE : ST_GAP;
                end
                ST_GAP:
                begin
                    if (t_done)
                    begin
                        if (t_start)
                        begin
                            state_q <= ST_OPEN;
                            if (MODE == MODE_TIMED)
                                left_q <= left_q - 16'h0001;
                        end
                        else
                        begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Valve opens only while the open phase timer runs.
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            VALVE_OPEN <= 1'b0;
        else
            VALVE_OPEN <= (state_q == ST_OPEN) && !t_done;
    end

    ////////////////////////////////////////////////////////////////////////
    // End-of-dispense pulse after each deposit, length clamped to 1..100.
    assign done_ms = (CFG.done_ms < DONE_MS_MIN) ? DONE_MS_MIN :
        (CFG.done_ms > DONE_MS_MAX) ? DONE_MS_MAX : CFG.done_ms;
    assign d_start = (state_q == ST_OPEN) && t_done;

    ms_timer #(.TICKS_PER_MS(TICKS_PER_MS)) u_done (
        .CLK(CLK),
        .ARST_N(ARST_N),
        .start(d_start),
        .ms({9'h000, done_ms}),
        .busy(d_busy),
        .done(d_done)
    );

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            DISPENSE_DONE <= 1'b0;
        else
            DISPENSE_DONE <= d_busy && !d_done;
    end

    ////////////////////////////////////////////////////////////////////////
    // Configurable inputs; high means on for power and purge.
    assign clear_req = (IN1_FUNC == CFG_DEFAULT) && CFG_IN1;

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            VALVE_POWER <= 1'b0;
            VALVE_PURGE <= 1'b0;
            HEATER_ENABLE <= 1'b0;
            ERROR_RESET <= 1'b0;
        end
        else
        begin
            ERROR_RESET <= clear_req;
            VALVE_POWER <= (IN1_FUNC == CFG_VALVE_POWER && CFG_IN1) ||
                (IN2_FUNC == CFG_VALVE_POWER && CFG_IN2);
            VALVE_PURGE <= (IN1_FUNC == CFG_VALVE_PURGE && CFG_IN1) ||
                (IN2_FUNC == CFG_VALVE_PURGE && CFG_IN2);
            HEATER_ENABLE <= (IN2_FUNC != CFG_DEFAULT) || !CFG_IN2;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Latched alarm: a new event in the clearing cycle wins over the clear.
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            alarm_q <= 1'b0;
        else if (ALARM_EVENT)
            alarm_q <= 1'b1;
        else if (clear_req)
            alarm_q <= 1'b0;
    end

    // Status outputs, registered so the pins never glitch.
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            TEMP_REACHED <= 1'b0;
            ERROR_N <= 1'b1;
            OVER_TEMP_OK_N <= 1'b1;
            POWER_STATUS <= 1'b0;
        end
        else
        begin
            // Sums carry one extra bit so a wide window cannot wrap.
            TEMP_REACHED <= ({1'b0, TEMP.actual} + {1'b0, TEMP.window} >=
                {1'b0, TEMP.target}) &&
                ({1'b0, TEMP.actual} <= {1'b0, TEMP.target} +
                {1'b0, TEMP.window});
            ERROR_N <= !(alarm_q || ALARM_EVENT);
            OVER_TEMP_OK_N <= !ACTUATOR_OVER_TEMP;
            POWER_STATUS <= CONTROLLER_ON;
        end
    end

endmodule

// ==== dispense_trigger_io_props.sv ====
`timescale 1ns/1ps

// Ties each watched output of the trigger block to its cause.
module dispense_trigger_io_props
    import dispense_pkg::*;
#(
    parameter int TICKS_PER_MS = CYCLES_PER_MS
)
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic INITIATE_VOLTAGE_IN,
    input wire dispense_cfg_t CFG,
    input wire logic CFG_IN1,
    input wire logic CFG_IN2,
    input wire input_func_t IN1_FUNC,
    input wire input_func_t IN2_FUNC,
    input wire logic ALARM_EVENT,
    input wire logic ACTUATOR_OVER_TEMP,
    input wire logic CONTROLLER_ON,
    input wire logic VALVE_OPEN,
    input wire logic DISPENSE_DONE,
    input wire logic ERROR_N,
    input wire logic OVER_TEMP_OK_N,
    input wire logic POWER_STATUS,
    input wire logic HEATER_ENABLE,
    input wire logic ERROR_RESET
);
    logic [9:0] hi_q;
    logic [7:0] qt_q;
    int dn;
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    ////////////////////////////////////////////////
    // Clamped done time; a zero setting must still give a pulse.
    assign dn = CFG.done_ms == 7'h00 ? 1
        : CFG.done_ms > 7'h64 ? 100 : int'(CFG.done_ms);
    // Length of the done pulse under way.
    always_ff @(posedge CLK or negedge ARST_N)
        if (!ARST_N)
            hi_q <= 10'h000;
        else
            hi_q <= DISPENSE_DONE ? hi_q + 10'h001 : 10'h000;
    // Idle time, saturating, so a start is judged only from rest.
    always_ff @(posedge CLK or negedge ARST_N)
        if (!ARST_N)
            qt_q <= 8'h00;
        else if (VALVE_OPEN || DISPENSE_DONE)
            qt_q <= 8'h00;
        else if (qt_q != 8'hff)
            qt_q <= qt_q + 8'h01;
    ////////////////////////////////////////////////
    property p_pwr;
        $past(ARST_N) |-> POWER_STATUS == $past(CONTROLLER_ON);
    endproperty
    a_pwr: assert property (p_pwr) else $error("power status");
    property p_hot;
        $past(ARST_N) |-> OVER_TEMP_OK_N == !$past(ACTUATOR_OVER_TEMP);
    endproperty
    a_hot: assert property (p_hot) else $error("over temp");
    property p_err;
        ALARM_EVENT |-> ##[1:2] !ERROR_N;
    endproperty
    a_err: assert property (p_err) else $error("alarm lost");
    property p_calm;
        ERROR_N && !ALARM_EVENT && !$past(ALARM_EVENT) |=> ERROR_N;
    endproperty
    a_calm: assert property (p_calm) else $error("false alarm");
    property p_rst;
        $past(ARST_N) |-> ERROR_RESET ==
            ($past(CFG_IN1) && $past(IN1_FUNC) == CFG_DEFAULT);
    endproperty
    a_rst: assert property (p_rst) else $error("error reset");
    property p_heat;
        $past(ARST_N) |-> HEATER_ENABLE ==
            ($past(IN2_FUNC) != CFG_DEFAULT || !$past(CFG_IN2));
    endproperty
    a_heat: assert property (p_heat) else $error("heater");
    property p_done;
        $fell(DISPENSE_DONE) |-> hi_q >= dn * TICKS_PER_MS
            && hi_q <= dn * TICKS_PER_MS + 1;
    endproperty
    a_done: assert property (p_done) else $error("done width");
    property p_go;
        $rose(INITIATE_VOLTAGE_IN) && qt_q == 8'hff |-> ##[3:12] VALVE_OPEN;
    endproperty
    a_go: assert property (p_go) else $error("no start");
endmodule

bind dispense_trigger_io dispense_trigger_io_props #(
    .TICKS_PER_MS(TICKS_PER_MS)
) props_inst (.*);

// ==== line_controller.sv ====
`timescale 1ns/1ps

// Machine side: a clean initiate level, one edge for each start.
module line_controller
(
    input wire logic CLK,
    output logic initiate
);
    initial initiate = 1'b0;
    // Raise once, hold, drop once; never a bounce.
    task automatic strobe(input int hi, input int lo);
        @(negedge CLK);
        initiate = 1'b1;
        repeat (hi) @(negedge CLK);
        initiate = 1'b0;
        repeat (lo) @(negedge CLK);
    endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps

module testbench
    import dispense_pkg::*;
;
    localparam int TK = 4;
    logic clk, arst_n, in1, in2, alarm, hot, on, init;
    logic vo, dd, tr, err_n, ok_n, pwr, heat, vpw, vpg, ers;
    logic vo_q = 1'b0;
    logic dd_q = 1'b0;
    logic [7:0] ev, mv;
    run_mode_t mode;
    dispense_cfg_t cfg;
    temp_info_t temp;
    input_func_t f1, f2;
    int failures = 0;
    int n_compared = 0;
    int n_open, n_done, len_bad, dt;
    int run = 0;
    int exp_len = 0;

    line_controller line_controller_inst (.CLK(clk), .initiate(init));
    dispense_trigger_io #(.TICKS_PER_MS(TK)) dispense_trigger_io_inst (
        .CLK(clk), .ARST_N(arst_n), .INITIATE_VOLTAGE_IN(init),
        .MODE(mode), .CFG(cfg), .EXT_OPEN_MS(16'h0003), .TEMP(temp),
        .CFG_IN1(in1), .CFG_IN2(in2), .IN1_FUNC(f1), .IN2_FUNC(f2),
        .ALARM_EVENT(alarm), .ACTUATOR_OVER_TEMP(hot), .CONTROLLER_ON(on),
        .VALVE_OPEN(vo), .DISPENSE_DONE(dd), .TEMP_REACHED(tr),
        .ERROR_N(err_n), .OVER_TEMP_OK_N(ok_n), .POWER_STATUS(pwr),
        .HEATER_ENABLE(heat), .VALVE_POWER(vpw), .VALVE_PURGE(vpg),
        .ERROR_RESET(ers));
    ////////////////////////////////////////////////
    // The 40 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Count openings and done pulses; judge each opening's length.
    always @(posedge clk)
    begin
        #1;
        if (vo)
            run++;
        else if (vo_q && (run < exp_len || run > exp_len + 1))
            len_bad++;
        if (!vo)
            run = 0;
        n_open += int'(vo && !vo_q);
        n_done += int'(dd && !dd_q);
        vo_q = vo;
        dd_q = dd;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask

    task automatic finish_test;
        if (failures == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Bounded wait until the block has rested; a hang ends the run.
    task automatic settle;
        int q = 0;
        for (int i = 0; i < 4000 && q < 300; i++)
        begin
            @(negedge clk);
            q = vo || dd ? 0 : q + 1;
        end
        if (q < 300)
        begin
            failures++;
            finish_test();
        end
    endtask
    // A batch of starts; n below zero asks for hi / (5 * TK) openings, or one more.
    task automatic burst(input run_mode_t m, input int p, k, d, e, hi, lo,
        input int n);
        mode = m;
        cfg = '{16'(p), 16'h0005, 16'(k), 7'(d)};
        exp_len = m == MODE_EXTERNAL ? 3 * TK : p * TK;
        n_open = 0;
        n_done = 0;
        len_bad = 0;
        repeat (e) line_controller_inst.strobe(hi, lo);
        settle();
        if (n >= 0)
            check(16'(n_open), 16'(n));
        else
            check({15'h0, n_open >= hi / (5 * TK) &&
                n_open <= hi / (5 * TK) + 1}, 16'h0001);
        check(16'(n_done), 16'(n_open));
        check(16'(len_bad), 16'h0000);
    endtask
    ////////////////////////////////////////////////
    initial
    begin
        {in1, in2, alarm, hot, on} = 5'h01;
        mode = MODE_TIMED;
        cfg = '0;
        temp = '{12'h1f4, 12'h1f4, 12'h03c};
        f1 = CFG_DEFAULT;
        f2 = CFG_DEFAULT;
        arst_n = 1'b0;
        void'($urandom(1));
        repeat (16) @(negedge clk);
        arst_n = 1'b1;
        // Random levels; each output follows its inputs one clock late.
        for (int i = 0; i < 300; i++)
        begin
            @(negedge clk);
            if (i > 0)
                check({8'h0, pwr, ok_n, heat, ers, tr, err_n, vpw, vpg} & mv,
                    {8'h0, ev & mv});
            {in1, in2, hot, on} = 4'($urandom_range(15));
            f1 = input_func_t'($urandom_range(2));
            f2 = input_func_t'(f1 == CFG_DEFAULT ? $urandom_range(2)
                : $urandom_range(1) * (3 - f1));
            temp.window = 12'(20 + $urandom_range(60));
            temp.actual = 12'(430 + $urandom_range(140));
            dt = temp.actual > 500 ? temp.actual - 500 : 500 - temp.actual;
            ev = {on, !hot, f2 != CFG_DEFAULT || !in2,
                in1 && f1 == CFG_DEFAULT, dt <= temp.window, 1'b1,
                f1 == CFG_VALVE_POWER && in1 || f2 == CFG_VALVE_POWER && in2,
                f1 == CFG_VALVE_PURGE && in1 || f2 == CFG_VALVE_PURGE && in2};
            mv = {6'h3f, f1 == CFG_VALVE_POWER || f2 == CFG_VALVE_POWER,
                f1 == CFG_VALVE_PURGE || f2 == CFG_VALVE_PURGE};
        end
        // The last random set is judged before the alarm scene drives on.
        @(negedge clk);
        check({8'h0, pwr, ok_n, heat, ers, tr, err_n, vpw, vpg} & mv,
            {8'h0, ev & mv});
        // A purge-mapped input must not clear a latched alarm.
        {in1, in2, hot, on, alarm} = 5'h13;
        f1 = CFG_VALVE_PURGE;
        f2 = CFG_DEFAULT;
        @(negedge clk);
        alarm = 1'b0;
        repeat (4) @(negedge clk);
        check({15'h0, err_n}, 16'h0000);
        f1 = CFG_DEFAULT;
        repeat (4) @(negedge clk);
        in1 = 1'b0;
        check({15'h0, err_n}, 16'h0001);
        burst(MODE_TIMED, 2, 3, 1, 2, 4, 8, 3);
        burst(MODE_TIMED, 1, 0, 0, 1, 3, 8, 1);
        burst(MODE_TIMED, 4, 1, 127, 1, 3, 8, 1);
        burst(MODE_EXTERNAL, 9, 5, 6, 3, 2, 100, 3);
        burst(MODE_CONTINUOUS, 2, 1, 1, 1, 150, 8, -1);
        finish_test();
    end
endmodule
